/* rtl/jisp_scan_path.v */
/*
  Boundary-scan data-register path limited to the identification and
  bypass registers, with a compact TAP controller. TCK, TMS and TDI
  come from an external host on another clock domain; core_clk
  oversamples them and acts on TCK edges. TDO data leaves through a
  two-entry buffer towards the pin driver, which may stall.
*/
`timescale 1ns/100ps
`include "jisp_consts.vh"

module jisp_scan_path #(
  parameter [31:0] ID_VALUE = `JISP_ID_VALUE  // arbitrary value
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output wire        tdo_valid,
  input  wire        tdo_ready,
  output reg         tdo,
  output reg         tdo_oe_n,
  output reg  [3:0]  ir_out,
  output reg         id_selected
);

  // =========================================================
  // tap states, one-hot
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002,
                    S_SDR = 16'h0004, S_CDR = 16'h0008,
                    S_SHD = 16'h0010, S_E1D = 16'h0020,
                    S_PDR = 16'h0040, S_E2D = 16'h0080,
                    S_UDR = 16'h0100, S_SIR = 16'h0200,
                    S_CIR = 16'h0400, S_SHI = 16'h0800,
                    S_E1I = 16'h1000, S_PIR = 16'h2000,
                    S_E2I = 16'h4000, S_UIR = 16'h8000;

  // =========================================================
  // decoding for the output stage; selects_id also feeds the data-register updates
  function is_shift_state;
    input [15:0] state;
    begin
      is_shift_state = (state == S_SHD) | (state == S_SHI);
    end
  endfunction

  function selects_id;
    input [3:0] code;
    begin
      selects_id = (code == `JISP_IR_IDCODE);
    end
  endfunction

  // =========================================================
  // input synchronisers
  reg  [2:0]  tck_s1_reg;
  reg  [2:0]  tck_s2_reg;
  reg         tck_d_reg;
  wire        tck_rise;
  wire        tck_fall;
  wire        tms_s;
  wire        tdi_s;

  // tms and tdi share the flops of tck, so all three stay aligned
  always @(posedge core_clk) begin
    if (reset) begin
      tck_s1_reg <= 3'h0;
      tck_s2_reg <= 3'h0;
      tck_d_reg  <= 1'b0;
    end else begin
      tck_s1_reg <= {tdi, tms, tck};
      tck_s2_reg <= tck_s1_reg;
      tck_d_reg  <= tck_s2_reg[0];
    end
  end
  assign tck_rise = tck_s2_reg[0] & ~tck_d_reg;
  assign tck_fall = ~tck_s2_reg[0] & tck_d_reg;
  assign tms_s    = tck_s2_reg[1];
  assign tdi_s    = tck_s2_reg[2];

  // =========================================================
  // tap controller
  reg  [15:0] state_reg;
  reg  [15:0] state_next;

  always @* begin
    case (state_reg)
      S_TLR:   state_next = tms_s ? S_TLR : S_RTI;
      S_RTI:   state_next = tms_s ? S_SDR : S_RTI;
      S_SDR:   state_next = tms_s ? S_SIR : S_CDR;
      S_CDR:   state_next = tms_s ? S_E1D : S_SHD;
      S_SHD:   state_next = tms_s ? S_E1D : S_SHD;
      S_E1D:   state_next = tms_s ? S_UDR : S_PDR;
      S_PDR:   state_next = tms_s ? S_E2D : S_PDR;
      S_E2D:   state_next = tms_s ? S_UDR : S_SHD;
      S_UDR:   state_next = tms_s ? S_SDR : S_RTI;
      S_SIR:   state_next = tms_s ? S_TLR : S_CIR;
      S_CIR:   state_next = tms_s ? S_E1I : S_SHI;
      S_SHI:   state_next = tms_s ? S_E1I : S_SHI;
      S_E1I:   state_next = tms_s ? S_UIR : S_PIR;
      S_PIR:   state_next = tms_s ? S_E2I : S_PIR;
      S_E2I:   state_next = tms_s ? S_UIR : S_SHI;
      S_UIR:   state_next = tms_s ? S_SDR : S_RTI;
      default: state_next = S_TLR;
    endcase
  end

  // =========================================================
  // instruction and data registers
  reg  [3:0]  ir_sh_reg;
  reg  [31:0] id_sh_reg;
  reg         byp_reg;
  wire        id_sel;
  wire        serial_in;

  assign id_sel    = selects_id(ir_out);
  // deliberate: identification shift ignores tdi entirely
  assign serial_in = id_sel ? 1'b1 : tdi_s;

  always @(posedge core_clk) begin
    if (reset) begin
      state_reg   <= S_TLR;
      ir_sh_reg   <= 4'h0;
      ir_out      <= `JISP_IR_IDCODE;
      id_sh_reg   <= 32'h0;
      byp_reg     <= 1'b0;
      id_selected <= 1'b1;
    end else begin
      // status level, one core_clk behind ir_out
      id_selected <= id_sel;
      if (tck_rise) begin
        state_reg <= state_next;
        // every pass through test-logic-reset restores the default
        case (state_reg)
          S_TLR:   ir_out <= `JISP_IR_IDCODE;
          S_CIR:   ir_sh_reg <= `JISP_IR_CAPTURE;
          S_SHI:   ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
          S_CDR: begin
            id_sh_reg <= ID_VALUE;
            byp_reg   <= 1'b0;
          end
          S_SHD: begin
            if (id_sel)
              id_sh_reg <= {serial_in, id_sh_reg[31:1]};
            byp_reg <= tdi_s;
          end
          // update-dr: id has no parallel latch, nothing is loaded
          S_UDR:   id_sh_reg <= id_sh_reg;
          S_UIR:   ir_out <= ir_sh_reg;
          default: ir_out <= ir_out;
        endcase
      end
    end
  end

  // =========================================================
  // tdo two-entry buffer; a stall keeps up to two bits queued, a third is dropped
  reg  [1:0]  buf_data_reg;
  reg  [1:0]  buf_cnt_reg;
  reg         shifting_reg;
  wire        push;
  wire        pop;
  wire        bit_out;

  assign bit_out = (state_reg == S_SHI) ? ir_sh_reg[0] :
                   id_sel ? id_sh_reg[0] : byp_reg;
  // limitation: tck cannot be held back, so a bit pushed while both
  // entries are full is dropped; the pin side must keep up
  assign push = tck_fall & shifting_reg & (buf_cnt_reg != 2'h2);
  assign pop  = tdo_valid & tdo_ready;
  assign tdo_valid = (buf_cnt_reg != 2'h0);

  always @(posedge core_clk) begin
    if (reset) begin
      buf_data_reg <= 2'h0;
      buf_cnt_reg  <= 2'h0;
      shifting_reg <= 1'b0;
      tdo          <= 1'b0;
      tdo_oe_n     <= 1'b1;
    end else begin
      if (tck_rise)
        shifting_reg <= is_shift_state(state_next);
      // tdo_oe_n falls with the first pop and rises once shifting ends
      if (pop) begin
        tdo      <= buf_data_reg[0];
        tdo_oe_n <= 1'b0;
      end else if (tck_fall & ~shifting_reg) begin
        tdo_oe_n <= 1'b1;
      end
      case ({push, pop})
        2'b10: begin
          buf_data_reg[buf_cnt_reg[0]] <= bit_out;
          buf_cnt_reg <= buf_cnt_reg + 2'h1;
        end
        2'b01: begin
          buf_data_reg <= {1'b0, buf_data_reg[1]};
          buf_cnt_reg  <= buf_cnt_reg - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_reg == 2'h1)
            buf_data_reg[0] <= bit_out;
          else
            buf_data_reg <= {bit_out, buf_data_reg[1]};
        end
        default: buf_cnt_reg <= buf_cnt_reg;
      endcase
    end
  end

endmodule // jisp_scan_path

/* rtl/jisp_consts.vh */
/*
  Constants for the identification scan path:
  instruction codes, register widths and reset values.
  Assumes plain Verilog-2005 inclusion by bare name.
*/
`ifndef JISP_CONSTS_VH
`define JISP_CONSTS_VH

`define JISP_IR_W          4
`define JISP_IR_IDCODE     4'h1
`define JISP_IR_BYPASS     4'hF
`define JISP_IR_CAPTURE    4'h1
`define JISP_ID_W          32
// arbitrary identification value; it names no maker or part
`define JISP_ID_VALUE      32'h1234A0B3
`define JISP_TRST_TMS_ONES 5

`endif

/* verif/jisp_properties.sv */
/* Port checks of jisp_scan_path; one clock domain, bound below. */
`timescale 1ns/100ps
module jisp_props (
  input wire       core_clk,
  input wire       reset,
  input wire       tdo_valid,
  input wire       tdo_ready,
  input wire       tdo,
  input wire       tdo_oe_n,
  input wire [3:0] ir_out,
  input wire       id_selected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rst; $fell(reset) |-> ir_out == 4'h1; endproperty
  a_rst: assert property (p_rst) else $error("no default ir");
  property p_sel; id_selected == ($past(ir_out) == 4'h1); endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_byp; ir_out == 4'hF |=> !id_selected; endproperty
  a_byp: assert property (p_byp) else $error("bad bypass");
  property p_idle; $fell(reset) |-> !tdo_valid && tdo_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_hold; tdo_valid && !tdo_ready |=> tdo_valid; endproperty
  a_hold: assert property (p_hold) else $error("bit lost");
  property p_tdo;
    $changed(tdo) |-> $past(tdo_valid) && $past(tdo_ready);
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved");
  property p_oe;
    $fell(tdo_oe_n) |-> $past(tdo_valid) && $past(tdo_ready);
  endproperty
  a_oe: assert property (p_oe) else $error("oe early");
endmodule // jisp_props
bind jisp_scan_path jisp_props u_props (
  .core_clk    (core_clk),
  .reset       (reset),
  .tdo_valid   (tdo_valid),
  .tdo_ready   (tdo_ready),
  .tdo         (tdo),
  .tdo_oe_n    (tdo_oe_n),
  .ir_out      (ir_out),
  .id_selected (id_selected)
);

/* verif/jisp_host.sv */
/* Host model: tck, tms, tdi of a one-device chain; tck idles low. */
`timescale 1ns/100ps
module jisp_host (
  output reg tck = 1'b0,
  output reg tms = 1'b1,
  output reg tdi = 1'b1
);
  task step(input m, input d);
    {tms, tdi} = {m, d};
    #80 tck = 1'b1;
    #80 tck = 1'b0;
  endtask
  task scan(input ir, input [63:0] din, input int n);
    step(1'b0, 1'b0);
    repeat (ir + 1) step(1'b1, 1'b0);
    repeat (2) step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i]);
    step(1'b1, 1'b0);
    step(1'b0, !din[n - 1]);
  endtask
endmodule // jisp_host

/* verif/jisp_scan_path_tb.sv */
/* Bench of jisp_scan_path with jisp_host; 50 MHz core clock. */
`timescale 1ns/100ps
`include "jisp_consts.vh"
module jisp_scan_path_tb;
  reg         core_clk = 1'b0, reset = 1'b1, tdo_ready = 1'b1, pop_d;
  reg  [63:0] got;
  integer     mismatches = 0, n_checks = 0;
  wire        tck, tms, tdi, tdo_valid, tdo, tdo_oe_n, id_selected;
  wire [3:0]  ir_out;
  always #10 core_clk = ~core_clk;
  jisp_host host (.tck, .tms, .tdi);
  jisp_scan_path dut (.core_clk, .reset, .tck, .tms, .tdi, .tdo_valid,
    .tdo_ready, .tdo, .tdo_oe_n, .ir_out, .id_selected);
  // pin side stalls while tck is high; the buffer must hold the bit
  always @(negedge core_clk) tdo_ready <= !tck;
  always @(posedge core_clk) pop_d <= tdo_valid && tdo_ready;
  always @(posedge core_clk) if (pop_d) got <= {tdo, got[63:1]};
  task check(input string what, input [63:0] seen, input [63:0] exp);
    n_checks = n_checks + 1;
    mismatches = mismatches + (seen !== exp);
    if (seen !== exp)
      $display("wrong value %s exp %h seen %h", what, exp, seen);
  endtask
  task dr(input ir, input [63:0] din, input int n, input [63:0] exp);
    host.scan(ir, din, n);
    check("scan out", got >> (64 - n), exp);
  endtask
  task t_idcode;
    dr(1'b0, 64'h0, 64, {32'hFFFFFFFF, `JISP_ID_VALUE});
    dr(1'b0, 64'h0, 32, {32'h0, `JISP_ID_VALUE});
  endtask
  task t_bypass;
    dr(1'b1, 64'hF, 4, 64'h1);
    check("ir", {59'h0, id_selected, ir_out}, {60'h0, `JISP_IR_BYPASS});
    dr(1'b0, 64'hB5C3, 16, 64'h6B86);
    repeat (`JISP_TRST_TMS_ONES) host.step(1'b1, 1'b0);
    dr(1'b0, 64'h0, 32, {32'h0, `JISP_ID_VALUE});
  endtask
  task final_report(input integer extra);
    mismatches = mismatches + extra;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // about 190 tck periods of scanning, so twice that is a hang
  initial #60000 final_report(1);
  initial begin
    repeat (6) @(negedge core_clk);
    reset <= 1'b0;
    t_idcode;
    t_bypass;
    final_report(0);
  end
endmodule // jisp_scan_path_tb
